// >>> src/prc_top.sv
// Power, reset and synthesizer control of the transceiver digital domain.
// Assumes clk is the digital clock and radio_state comes from the same domain.
`timescale 1ns/1ps
// Notes on behaviour
// - Level code 001 is 1.2 V up to 111 at 1.8 V, 100 mV steps.
// - Transmit-only mode forces 1.4 V in receive; otherwise the code applies.
// - Fractional switching off: switching clock is digital clock divided by 4.
// - Fractional switching on: rate is word times digital clock over 2^15.
// - Digital clock is crystal for 24-26 MHz, crystal halved for 48-52 MHz.
// - Power-up holds internal reset low 0.7-2 ms and restores all defaults.
// - Same pulse follows shutdown release; shutdown must last 1 us to count.
// - Internal reset is driven out on the first general-purpose pin.
// - Soft reset command performs only a partial reset.
// - Shutdown high raises pad-off, disabling all digital pads.
// - Calibrate synthesizer on ready-to-active and rx/tx swaps; store the word.
// - Centre frequency is base plus index times step, scaled fxo over 2^15.
// - Base is fxo times word over 2^20, divided by B/2 times D.
// - Band divider is 4 for band bit 0, 8 for band bit 1.
// - Reference divider is 1 for halver bit 0, 2 for halver bit 1.
// - Channel index is an 8-bit register, 256 channels.
module prc_top
  import prc_pkg::*;
#(
  parameter int unsigned RESET_PULSE_CYCLES = prc_pkg::RESET_CYCLES
)
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          shutdown_pin,
  input  wire logic [4:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output logic      [7:0]    reg_rdata,
  input  wire logic [2:0]    radio_state,
  input  wire logic          cal_done,
  input  wire logic [6:0]    cal_result,
  output logic               cal_start,
  output logic      [6:0]    synth_cal_word,
  output logic               internal_rst_low,
  output logic               first_gp_pin,
  output logic               pad_off_control,
  output logic      [2:0]    converter_level,
  output logic      [10:0]   converter_level_mv,
  output logic               converter_switch_clk,
  output logic               regulator_bypass,
  output logic               xo_div2_sel,
  output logic      [2:0]    pump_current_sel,
  output logic               detector_split_en,
  output logic      [27:0]   base_ratio,
  output logic      [28:0]   center_ratio
);
  typedef struct packed {
    logic        sd_meta;
    logic        sd_sync;
    logic [5:0]  sd_cnt;
    logic [15:0] rst_cnt;
    logic        rst_low;
    logic        pad_off;
    logic [2:0]  lvl_sel;
    logic        tx_only;
    logic        bypass;
    logic        xo_double;
    logic        frac_en;
    logic [14:0] rate;
    logic [27:0] base;
    logic        band;
    logic        ref_half;
    logic        split;
    logic [2:0]  pump;
    logic        cal_off;
    logic [7:0]  step;
    logic [7:0]  chan;
    logic [6:0]  cal_rx;
    logic [6:0]  cal_tx;
    prc_cal_t    cal;
    logic        cal_for_tx;
    logic        cal_start;
    logic [2:0]  prev_state;
    logic [2:0]  lvl_out;
    logic [10:0] lvl_mv;
    logic        soft_rst;
    logic [7:0]  rdata;
    logic [6:0]  cal_word;
  } prc_state_t;

  localparam logic [15:0] PULSE = 16'(RESET_PULSE_CYCLES);
  localparam logic [5:0]  HOLD  = 6'(SD_HOLD_CYCLES);

  prc_state_t s;
  prc_state_t next_s;
  logic       trig;
  logic       wr;
  prc_core_if core ();

  // ----------------------------------------
  // Configuration defaults
  // ----------------------------------------
  function automatic prc_state_t cfg_default(input prc_state_t x);
    prc_state_t y;
    y = x;
    y.lvl_sel = LVL_RESET;
    y.tx_only = 1'b0;
    y.bypass = 1'b0;
    y.xo_double = 1'b0;
    y.frac_en = 1'b0;
    y.rate = '0;
    y.base = BASE_RESET;
    y.band = 1'b0;
    y.ref_half = 1'b0;
    y.split = 1'b0;
    y.pump = PUMP_RESET;
    y.cal_off = 1'b0;
    y.step = STEP_RESET;
    y.chan = '0;
    y.cal_rx = '0;
    y.cal_tx = '0;
    y.cal = CAL_IDLE;
    cfg_default = y;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    wr = reg_write && s.rst_low;
    next_s.soft_rst = 1'b0;
    next_s.cal_start = 1'b0;
    next_s.rdata = '0;
    // Pin is asynchronous, so two stages before use
    next_s.sd_meta = shutdown_pin;
    next_s.sd_sync = s.sd_meta;
    next_s.pad_off = s.sd_sync;
    if (s.sd_sync)
    begin
      next_s.sd_cnt = (s.sd_cnt == HOLD) ? s.sd_cnt : s.sd_cnt + 6'h01;
    end
    else
    begin
      next_s.sd_cnt = '0;
    end
    // Short shutdown glitches leave the reset counter alone
    if (s.sd_sync && s.sd_cnt == HOLD)
    begin
      next_s.rst_cnt = PULSE;
    end
    else if (s.rst_cnt != '0)
    begin
      next_s.rst_cnt = s.rst_cnt - 16'h0001;
    end

    if (wr)
    begin
      case (reg_addr)
        OFS_PWR_A:
        begin
          if (reg_wdata[2:0] != LVL_BAD)
          begin
            next_s.lvl_sel = reg_wdata[2:0];
          end
        end
        OFS_PWR_B:
        begin
          next_s.tx_only = reg_wdata[0];
          next_s.bypass = reg_wdata[1];
          next_s.xo_double = reg_wdata[2];
        end
        OFS_PWR_C: next_s.rate[7:0] = reg_wdata;
        OFS_PWR_D:
        begin
          next_s.rate[14:8] = reg_wdata[6:0];
          next_s.frac_en = reg_wdata[7];
        end
        OFS_SYN3:
        begin
          next_s.base[27:24] = reg_wdata[3:0];
          next_s.band = reg_wdata[4];
          next_s.pump = reg_wdata[7:5];
        end
        OFS_SYN2: next_s.base[23:16] = reg_wdata;
        OFS_SYN1: next_s.base[15:8] = reg_wdata;
        OFS_SYN0: next_s.base[7:0] = reg_wdata;
        OFS_SCFG:
        begin
          next_s.split = reg_wdata[0];
          next_s.ref_half = reg_wdata[1];
          next_s.cal_off = reg_wdata[2];
        end
        OFS_STEP: next_s.step = reg_wdata;
        OFS_CHAN: next_s.chan = reg_wdata;
        OFS_CALRX: next_s.cal_rx = reg_wdata[6:0];
        OFS_CALTX: next_s.cal_tx = reg_wdata[6:0];
        OFS_CMD: next_s.soft_rst = reg_wdata[0];
        default: next_s.rdata = '0;
      endcase
    end

    if (reg_read)
    begin
      case (reg_addr)
        OFS_PWR_A: next_s.rdata = {5'h00, s.lvl_sel};
        OFS_PWR_B: next_s.rdata = {5'h00, s.xo_double, s.bypass, s.tx_only};
        OFS_PWR_C: next_s.rdata = s.rate[7:0];
        OFS_PWR_D: next_s.rdata = {s.frac_en, s.rate[14:8]};
        OFS_SYN3: next_s.rdata = {s.pump, s.band, s.base[27:24]};
        OFS_SYN2: next_s.rdata = s.base[23:16];
        OFS_SYN1: next_s.rdata = s.base[15:8];
        OFS_SYN0: next_s.rdata = s.base[7:0];
        OFS_SCFG: next_s.rdata = {5'h00, s.cal_off, s.ref_half, s.split};
        OFS_STEP: next_s.rdata = s.step;
        OFS_CHAN: next_s.rdata = s.chan;
        OFS_CALRX: next_s.rdata = {1'b0, s.cal_rx};
        OFS_CALTX: next_s.rdata = {1'b0, s.cal_tx};
        OFS_STAT: next_s.rdata = {3'h0, s.pad_off, s.cal == CAL_RUN, s.lvl_out};
        default: next_s.rdata = '0;
      endcase
    end

    // ----------------------------------------
    // Synthesizer calibration
    // ----------------------------------------
    trig = (s.prev_state == RS_READY &&
            (radio_state == RS_LOCK || radio_state == RS_RX || radio_state == RS_TX)) ||
           (s.prev_state == RS_RX && radio_state == RS_TX) ||
           (s.prev_state == RS_TX && radio_state == RS_RX);
    next_s.prev_state = radio_state;
    case (s.cal)
      CAL_IDLE:
      begin
        if (trig && !s.cal_off)
        begin
          next_s.cal = CAL_RUN;
          next_s.cal_start = 1'b1;
          next_s.cal_for_tx = (radio_state == RS_TX);
        end
      end
      CAL_RUN:
      begin
        // Hardware result wins over a word write in the same cycle, but not over a soft reset
        if (cal_done)
        begin
          next_s.cal = CAL_IDLE;
          if (s.cal_for_tx)
          begin
            next_s.cal_tx = cal_result;
          end
          else
          begin
            next_s.cal_rx = cal_result;
          end
        end
      end
      default: next_s.cal = CAL_IDLE;
    endcase

    // Partial reset: calibration here and the switching clock in prc_swclk, power and synth settings kept
    if (next_s.soft_rst)
    begin
      next_s.cal = CAL_IDLE;
      next_s.cal_rx = '0;
      next_s.cal_tx = '0;
    end

    if (reset)
    begin
      next_s = '0;
      next_s.rst_cnt = PULSE;
    end
    if (next_s.rst_cnt != '0)
    begin
      next_s = cfg_default(next_s);
    end
    next_s.rst_low = (next_s.rst_cnt == '0);
    // Receive runs at 1.4 V when the level is for transmit only
    next_s.lvl_out = (next_s.tx_only && radio_state == RS_RX) ? LVL_1V4 : next_s.lvl_sel;
    next_s.lvl_mv = level_mv(next_s.lvl_out);
    next_s.cal_word = (radio_state == RS_TX) ? next_s.cal_tx : next_s.cal_rx;
  end

  always_ff @(posedge clk)
  begin
    s <= next_s;
  end

  // ----------------------------------------
  // Helper blocks
  // ----------------------------------------
  assign core.frac_en = s.frac_en;
  assign core.rate_word = s.rate;
  assign core.soft_rst = s.soft_rst;
  assign core.base_word = s.base;
  assign core.band_select = s.band;
  assign core.ref_halver_en = s.ref_half;
  assign core.chan_step_word = s.step;
  assign core.chan_index = s.chan;

  prc_swclk u_swclk (
    .clk   (clk),
    .reset (!s.rst_low),
    .io    (core.sw)
  );

  prc_freq u_freq (
    .clk   (clk),
    .reset (!s.rst_low),
    .io    (core.fq)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = s.rdata;
  assign cal_start = s.cal_start;
  assign synth_cal_word = s.cal_word;
  assign internal_rst_low = s.rst_low;
  assign first_gp_pin = s.rst_low;
  assign pad_off_control = s.pad_off;
  assign converter_level = s.lvl_out;
  assign converter_level_mv = s.lvl_mv;
  assign converter_switch_clk = core.sw_clk;
  assign regulator_bypass = s.bypass;
  assign xo_div2_sel = s.xo_double;
  assign pump_current_sel = s.pump;
  assign detector_split_en = s.split;
  assign base_ratio = core.base_ratio;
  assign center_ratio = core.center_ratio;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence sd_held;
    shutdown_pin [*3];
  endsequence
  sequence ready_then_rx;
    radio_state == RS_READY ##1 radio_state == RS_RX && s.cal == CAL_IDLE && !s.cal_off;
  endsequence

  a_rx_level_forced: assert property (s.tx_only && radio_state == RS_RX |=>
    converter_level == LVL_1V4) else $error("receive level not 1.4 V");
  a_level_mv_map: assert property (converter_level_mv ==
    MV_BASE + 11'(converter_level) * MV_STEP) else $error("level voltage mismatch");
  a_zero_level_kept: assert property (wr && reg_addr == OFS_PWR_A &&
    reg_wdata[2:0] == LVL_BAD |=> $stable(s.lvl_sel)) else $error("code 000 applied");
  a_pad_off_follow: assert property (sd_held |=> pad_off_control)
    else $error("pads not switched off");
  a_sd_pulse_start: assert property (s.sd_sync && s.sd_cnt == HOLD |=>
    !internal_rst_low [*8]) else $error("shutdown reset pulse too short");
  a_gp_mirror: assert property ($past(reset) |-> !first_gp_pin &&
    first_gp_pin == internal_rst_low) else $error("gp pin does not show reset");
  a_cfg_defaults: assert property (!internal_rst_low |-> s.lvl_sel == LVL_RESET &&
    s.step == STEP_RESET) else $error("defaults not held in reset");
  a_soft_partial: assert property (wr && reg_addr == OFS_CMD && reg_wdata[0] |=>
    $stable(s.base) && s.cal_rx == '0 && s.cal == CAL_IDLE) else $error("soft reset wrong");
  a_cal_trigger: assert property (ready_then_rx |=> cal_start)
    else $error("calibration not started");
  a_cal_store: assert property (s.cal == CAL_RUN && cal_done && s.cal_for_tx &&
    !(wr && reg_addr == OFS_CMD) |=> s.cal_tx == $past(cal_result)) else $error("cal not stored");
endmodule

// >>> src/prc_pkg.sv
// Constants and types shared by the power, reset and synthesizer control.
// Assumes a 50 MHz digital clock and an 8-bit register port.
package prc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
  localparam int unsigned RESET_MIN_US   = 700;
  localparam int unsigned RESET_CYCLES   = RESET_MIN_US * CLK_MHZ;
  localparam int unsigned SD_HOLD_US     = 1;
  localparam int unsigned SD_HOLD_CYCLES = SD_HOLD_US * CLK_MHZ;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_PWR_A = 5'h00;
  localparam logic [4:0] OFS_PWR_B = 5'h01;
  localparam logic [4:0] OFS_PWR_C = 5'h02;
  localparam logic [4:0] OFS_PWR_D = 5'h03;
  localparam logic [4:0] OFS_SYN3  = 5'h04;
  localparam logic [4:0] OFS_SYN2  = 5'h05;
  localparam logic [4:0] OFS_SYN1  = 5'h06;
  localparam logic [4:0] OFS_SYN0  = 5'h07;
  localparam logic [4:0] OFS_SCFG  = 5'h08;
  localparam logic [4:0] OFS_STEP  = 5'h09;
  localparam logic [4:0] OFS_CHAN  = 5'h0A;
  localparam logic [4:0] OFS_CALRX = 5'h0B;
  localparam logic [4:0] OFS_CALTX = 5'h0C;
  localparam logic [4:0] OFS_STAT  = 5'h0D;
  localparam logic [4:0] OFS_CMD   = 5'h0E;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [2:0] LVL_RESET = 3'h4;
  localparam logic [2:0] LVL_1V4   = 3'h3;
  localparam logic [2:0] LVL_BAD   = 3'h0;
  localparam logic [7:0] STEP_RESET = 8'h3F;
  localparam logic [27:0] BASE_RESET = 28'h62B8520;
  localparam logic [2:0] PUMP_RESET = 3'h2;
  localparam logic [2:0] RS_READY = 3'h0;
  localparam logic [2:0] RS_LOCK  = 3'h1;
  localparam logic [2:0] RS_RX    = 3'h2;
  localparam logic [2:0] RS_TX    = 3'h3;
  localparam logic [10:0] MV_BASE = 11'h44C;
  localparam logic [10:0] MV_STEP = 11'h064;
  typedef enum logic {CAL_IDLE, CAL_RUN} prc_cal_t;

  // Converter level code to millivolts
  function automatic logic [10:0] level_mv(input logic [2:0] code);
    level_mv = MV_BASE + 11'(code) * MV_STEP;
  endfunction
endpackage

// >>> src/prc_core_if.sv
// Signals between the control top and its two helper blocks.
// Assumes all three run on the same digital clock.
`timescale 1ns/1ps
interface prc_core_if;
  logic        frac_en;
  logic [14:0] rate_word;
  logic        soft_rst;
  logic        sw_clk;
  logic [27:0] base_word;
  logic        band_select;
  logic        ref_halver_en;
  logic [7:0]  chan_step_word;
  logic [7:0]  chan_index;
  logic [27:0] base_ratio;
  logic [28:0] center_ratio;
  modport top (output frac_en, rate_word, soft_rst, base_word, band_select,
               ref_halver_en, chan_step_word, chan_index,
               input sw_clk, base_ratio, center_ratio);
  modport sw (input frac_en, rate_word, soft_rst, output sw_clk);
  modport fq (input base_word, band_select, ref_halver_en, chan_step_word,
              chan_index, output base_ratio, center_ratio);
endinterface

// >>> src/prc_swclk.sv
// Converter switching clock: fixed divide by 4 or phase accumulator.
// Assumes the rate word is static while in use.
`timescale 1ns/1ps
module prc_swclk
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  prc_core_if.sw   io
);
  typedef struct packed {
    logic [14:0] acc;
    logic [1:0]  div;
    logic        clk_out;
  } prc_sw_t;
  prc_sw_t s;
  prc_sw_t next_s;

  always_comb
  begin
    next_s = s;
    if (reset || io.soft_rst)
    begin
      next_s = '0;
    end
    else if (io.frac_en)
    begin
      // Accumulator MSB gives rate * fclk / 2^15
      next_s.acc = s.acc + io.rate_word;
      next_s.clk_out = next_s.acc[14];
    end
    else
    begin
      next_s.div = s.div + 2'h1;
      next_s.clk_out = next_s.div[1];
    end
  end

  always_ff @(posedge clk)
  begin
    s <= next_s;
  end
  assign io.sw_clk = s.clk_out;

  default clocking @(posedge clk); endclocking
  default disable iff (reset || io.soft_rst);
  a_div4_period: assert property (!io.frac_en [*5] ##0 $rose(s.clk_out)
    |-> ##4 $rose(s.clk_out) || io.frac_en) else $error("divide by 4 period wrong");
endmodule

// >>> src/prc_freq.sv
// Base and channel centre frequency words, in units of fxo / 2^20.
// Assumes the inputs come from registers on the same clock.
`timescale 1ns/1ps
module prc_freq
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  prc_core_if.fq   io
);
  typedef struct packed {
    logic [27:0] base;
    logic [28:0] center;
  } prc_fq_t;
  prc_fq_t s;
  prc_fq_t next_s;
  logic [1:0]  shift;
  logic [20:0] chan_off;

  always_comb
  begin
    // B/2 * D is 2, 4 or 8, so the divide is a shift
    shift = io.band_select ? 2'h2 : 2'h1;
    shift = shift + {1'b0, io.ref_halver_en};
    // 2^20 / 2^15 leaves a shift of five
    // Widened first: inside a concatenation the product would keep only 8 bits
    chan_off = {16'(io.chan_step_word) * 16'(io.chan_index), 5'h00};
    next_s.base = io.base_word >> shift;
    next_s.center = {1'b0, next_s.base} + 29'(chan_off);
    if (reset)
    begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    s <= next_s;
  end
  assign io.base_ratio = s.base;
  assign io.center_ratio = s.center;
endmodule

// >>> testbench/prc_cal_partner.sv
// Model of the synthesizer calibration engine at the far side of the block.
// Assumes cal_start is a one-cycle pulse; answers after LAT cycles.
`timescale 1ns/1ps
module prc_cal_partner
#(
  parameter int LAT = 5
)
(
  input  wire logic       clk,
  input  wire logic       cal_start,
  input  wire logic [6:0] result_value,
  output logic            cal_done,
  output logic      [6:0] cal_result
);
  // ----------------------------------------
  // Calibration answer
  // ----------------------------------------
  int         cnt;
  logic [6:0] last;

  initial
  begin
    cal_done   = 1'b0;
    cal_result = 7'h55;
    cnt        = 0;
    last       = 7'h00;
  end

  always @(posedge clk)
  begin
    cal_done   <= 1'b0;
    // Result is not held: outside the done cycle show the inverse
    cal_result <= ~last;
    if (cal_start === 1'b1)
      cnt <= LAT;
    else if (cnt == 1)
    begin
      cal_done   <= 1'b1;
      cal_result <= result_value;
      last       <= result_value;
      cnt        <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// >>> testbench/prc_top_tb.sv
// Self-checking bench for the power, reset and synthesizer control.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin \
  fail_count++; $display("mismatch at %0t: %s", $time, msg); end end
module prc_top_tb;
  import prc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int unsigned PULSE = 16;
  logic        clk, reset, shutdown_pin, reg_write, reg_read, cal_done, cal_start;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [2:0]  radio_state, converter_level, pump_current_sel;
  logic [6:0]  cal_result, synth_cal_word, cal_value;
  logic        internal_rst_low, first_gp_pin, pad_off_control, converter_switch_clk;
  logic        regulator_bypass, xo_div2_sel, detector_split_en;
  logic [10:0] converter_level_mv;
  logic [27:0] base_ratio, exp_base;
  logic [28:0] center_ratio;
  int          fail_count, samples_checked, starts, rises;

  prc_top #(.RESET_PULSE_CYCLES(PULSE)) dut (.clk(clk), .reset(reset),
    .shutdown_pin(shutdown_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .radio_state(radio_state), .cal_done(cal_done), .cal_result(cal_result),
    .cal_start(cal_start), .synth_cal_word(synth_cal_word),
    .internal_rst_low(internal_rst_low), .first_gp_pin(first_gp_pin),
    .pad_off_control(pad_off_control), .converter_level(converter_level),
    .converter_level_mv(converter_level_mv), .converter_switch_clk(converter_switch_clk),
    .regulator_bypass(regulator_bypass), .xo_div2_sel(xo_div2_sel),
    .pump_current_sel(pump_current_sel), .detector_split_en(detector_split_en),
    .base_ratio(base_ratio), .center_ratio(center_ratio));

  prc_cal_partner #(.LAT(5)) partner (.clk(clk), .cal_start(cal_start),
    .result_value(cal_value), .cal_done(cal_done), .cal_result(cal_result));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
    if (cal_start === 1'b1)
      starts++;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Gap cycle after each strobe so no signal is assigned twice in a step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, exp, "register read")
    @(posedge clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic count_rises(input int n);
    logic prev;
    #1;
    prev  = converter_switch_clk;
    rises = 0;
    repeat (n)
    begin
      cyc(1);
      if (converter_switch_clk === 1'b1 && prev === 1'b0)
        rises++;
      prev = converter_switch_clk;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Whole sequence needs about five hundred cycles; ten thousand is a wide margin
  initial
  begin
    #200_000;
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    reset = 1'b1; shutdown_pin = 1'b0; reg_write = 1'b0; reg_read = 1'b0;
    reg_addr = 5'h00; reg_wdata = 8'h00; radio_state = RS_READY; cal_value = 7'h2A;
    fail_count = 0; samples_checked = 0; starts = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    cyc(10);
    `CHK(internal_rst_low, 1'b0, "reset pulse too short")
    `CHK(first_gp_pin, internal_rst_low, "gp pin differs")
    cyc(12);
    `CHK(internal_rst_low, 1'b1, "reset pulse not ended")
    `CHK(converter_level_mv, 11'h5DC, "default level")
    chk_rd(OFS_STEP, 8'h3F);
    // Calibration off while the levels are exercised; words set by hand
    wr(OFS_SCFG, 8'h04);
    wr(OFS_CALRX, 8'h11);
    wr(OFS_CALTX, 8'h22);
    wr(OFS_PWR_B, 8'h02);
    wr(OFS_PWR_A, 8'h01);
    cyc(2);
    `CHK(regulator_bypass, 1'b1, "bypass not set")
    `CHK(converter_level_mv, 11'h4B0, "low power level")
    for (int c = 1; c < 8; c++)
    begin
      wr(OFS_PWR_A, 8'(c));
      cyc(2);
      `CHK(converter_level_mv, 11'(1100 + 100 * c), "level mv")
    end
    wr(OFS_PWR_A, 8'h00);
    cyc(2);
    `CHK(converter_level, 3'h7, "code 000 applied")
    wr(OFS_PWR_B, 8'h05);
    radio_state <= RS_RX;
    cyc(3);
    `CHK(converter_level, 3'h3, "rx level in tx-only")
    `CHK(xo_div2_sel, 1'b1, "crystal halver")
    `CHK(regulator_bypass, 1'b0, "bypass not cleared")
    `CHK(synth_cal_word, 7'h11, "rx word by hand")
    radio_state <= RS_TX;
    cyc(3);
    `CHK(converter_level, 3'h7, "tx level in tx-only")
    `CHK(synth_cal_word, 7'h22, "tx word by hand")
    wr(OFS_PWR_B, 8'h00);
    radio_state <= RS_RX;
    cyc(3);
    `CHK(converter_level, 3'h7, "rx level in both mode")
    `CHK(starts, 0, "calibration while disabled")
    radio_state <= RS_READY;
    count_rises(40);
    `CHK(rises, 10, "divide by 4")
    wr(OFS_PWR_C, 8'h00);
    wr(OFS_PWR_D, 8'h90);
    count_rises(80);
    `CHK(rises, 10, "fractional rate")
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_SYN3, {3'h2, 1'(k), 4'h1});
      wr(OFS_SYN2, 8'h23);
      wr(OFS_SYN1, 8'h45);
      wr(OFS_SYN0, 8'h68);
      wr(OFS_SCFG, {5'h00, 1'b1, 1'(k >> 1), 1'b0});
      cyc(3);
      exp_base = 28'h1234568 >> (1 + (k & 1) + (k >> 1));
      `CHK(base_ratio, exp_base, "base ratio")
      `CHK(pump_current_sel, PUMP_RESET, "pump select")
    end
    wr(OFS_CHAN, 8'hFF);
    cyc(3);
    `CHK(center_ratio, 29'(exp_base) + 29'(63 * 255 * 32), "center ratio")
    wr(OFS_SYN3, 8'h21);
    wr(OFS_SCFG, 8'h05);
    cyc(1);
    `CHK(detector_split_en, 1'b1, "detector split")
    `CHK(pump_current_sel, 3'h1, "pump select low crystal")
    wr(OFS_SCFG, 8'h00);
    radio_state <= RS_RX;
    cyc(12);
    `CHK(starts, 1, "no calibration on ready to rx")
    `CHK(synth_cal_word, 7'h2A, "rx word")
    chk_rd(OFS_CALRX, 8'h2A);
    cal_value   <= 7'h15;
    radio_state <= RS_TX;
    cyc(12);
    `CHK(starts, 2, "no calibration on rx to tx")
    `CHK(synth_cal_word, 7'h15, "tx word")
    wr(OFS_CMD, 8'h01);
    chk_rd(OFS_CALTX, 8'h00);
    chk_rd(OFS_CHAN, 8'hFF);
    radio_state <= RS_READY;
    chk_rd(5'h1F, 8'h00);
    wr(OFS_STAT, 8'hFF);
    chk_rd(OFS_STAT, 8'h07);
    shutdown_pin <= 1'b1;
    cyc(6);
    `CHK(pad_off_control, 1'b1, "pad off on shutdown")
    shutdown_pin <= 1'b0;
    cyc(30);
    `CHK(internal_rst_low, 1'b1, "short shutdown reset")
    shutdown_pin <= 1'b1;
    cyc(100);
    `CHK(internal_rst_low, 1'b0, "no reset in shutdown")
    shutdown_pin <= 1'b0;
    cyc(10);
    `CHK(internal_rst_low, 1'b0, "reset after shutdown")
    cyc(30);
    `CHK(internal_rst_low, 1'b1, "reset after shutdown stuck")
    `CHK(pad_off_control, 1'b0, "pad off stuck")
    chk_rd(OFS_CHAN, 8'h00);
    tally_and_finish();
  end
endmodule
